// file: hw/iorabu_consts.vh
// constants for the input read, accumulator, compare and conditional jump unit
`ifndef IORABU_CONSTS_VH
`define IORABU_CONSTS_VH
// instruction codes
`define IORABU_INS_INPUT_READ 8'h0F
`define IORABU_INS_ARITH 8'h13
`define IORABU_INS_COMPARE 8'h14
`define IORABU_INS_COND_JUMP 8'h15
// input read banks
`define IORABU_BANK_DIGITAL 8'h00
`define IORABU_BANK_ANALOG 8'h01
`define IORABU_BANK_OUTPUTS 8'h02
// arithmetic operations
`define IORABU_OP_ADD 8'h00
`define IORABU_OP_SUB 8'h01
`define IORABU_OP_PRODUCT 8'h02
`define IORABU_OP_DIV 8'h03
`define IORABU_OP_REMAINDER 8'h04
`define IORABU_OP_AND 8'h05
`define IORABU_OP_OR 8'h06
`define IORABU_OP_XOR 8'h07
`define IORABU_OP_INVERT 8'h08
`define IORABU_OP_LOAD 8'h09
// jump conditions
`define IORABU_COND_NULL 8'h00
`define IORABU_COND_NONNULL 8'h01
`define IORABU_COND_SAME 8'h02
`define IORABU_COND_DIFFER 8'h03
`define IORABU_COND_ABOVE_STRICT 8'h04
`define IORABU_COND_ABOVE_OR_SAME 8'h05
`define IORABU_COND_BELOW_STRICT 8'h06
`define IORABU_COND_BELOW_OR_SAME 8'h07
`define IORABU_COND_TIMEOUT 8'h08
`define IORABU_COND_ALARM 8'h09
`define IORABU_COND_DEVIATION 8'h0A
`define IORABU_COND_POSITION 8'h0B
// reply status codes
`define IORABU_STATUS_OK 8'h64
`define IORABU_STATUS_BAD_TYPE 8'h03
`define IORABU_STATUS_BAD_CMD 8'h02
// register byte offsets
`define IORABU_REG_CMD 8'h00
`define IORABU_REG_VALUE 8'h04
`define IORABU_REG_STATUS 8'h08
`define IORABU_REG_RESULT 8'h0C
`define IORABU_REG_ACCU 8'h10
`define IORABU_REG_PC 8'h14
`define IORABU_REG_OUTPUTS 8'h18
`define IORABU_REG_ERRORS 8'h1C
// field positions in the command register
`define IORABU_CMD_INS_LSB 0
`define IORABU_CMD_TYPE_LSB 8
`define IORABU_CMD_BANK_LSB 16
`define IORABU_CMD_STANDALONE_BIT 24
// reset values
`define IORABU_RST_WORD 32'h00000000
`endif

// file: hw/iorabu_top.v
// command execution unit for input read, accumulator arithmetic, compare and conditional jump
// Contract
// - each of the four input lines reads as digital and analogue at once
// - bank 0 read returns the selected line's digital level as 0 or 1
// - bank 1 read returns the selected line's analogue value unsigned
// - bank 2 read returns the driven state of the selected output line
// - instruction 19 applies one selectable operation with a constant operand
// - type selects add, sub, mul, div, mod, and, or, xor, invert, load
// - every arithmetic result is stored back into the accumulator; div and mod by a zero operand leave it unchanged
// - arithmetic in direct mode replies status 100 with the operand as value
// - arithmetic is accepted in direct mode as well as standalone
// - instruction 20 compares accumulator with operand, ignoring type and bank
// - compare updates the status flags used by a later conditional jump
// - instruction 21 loads the program counter when the condition holds
// - jump types 0 to 7 test zero, equal, greater and lower flags
// - jump types 8 to 11 test timeout, alarm, deviation, position errors
// - analogue reads span 0 to 65535, digital reads only 0 or 1
// - standalone input read loads the accumulator, direct mode leaves it
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "iorabu_consts.vh"

module iorabu_top #(
    parameter LINES = 4,
    parameter ADC_W = 16
) (
    input wire CLOCK_I,
    input wire RST_B_I,
    // axi4-lite slave
    input wire [7:0] S_AXI_AWADDR_I,
    input wire S_AXI_AWVALID_I,
    output reg S_AXI_AWREADY_O,
    input wire [31:0] S_AXI_WDATA_I,
    input wire [3:0] S_AXI_WSTRB_I,
    input wire S_AXI_WVALID_I,
    output reg S_AXI_WREADY_O,
    output reg [1:0] S_AXI_BRESP_O,
    output reg S_AXI_BVALID_O,
    input wire S_AXI_BREADY_I,
    input wire [7:0] S_AXI_ARADDR_I,
    input wire S_AXI_ARVALID_I,
    output reg S_AXI_ARREADY_O,
    output reg [31:0] S_AXI_RDATA_O,
    output reg [1:0] S_AXI_RRESP_O,
    output reg S_AXI_RVALID_O,
    input wire S_AXI_RREADY_I,
    // combined analogue/digital inputs, converter results per line
    input wire [LINES-1:0] INPUT_LINE_I,
    input wire [LINES*ADC_W-1:0] ADC_VALUE_I,
    // error sources for the conditional jump
    input wire TIMEOUT_ERROR_I,
    input wire EXTERNAL_ALARM_I,
    input wire DEVIATION_ERROR_I,
    input wire POSITION_ERROR_I,
    // output lines (driven by writes to the outputs register below)
    output reg [LINES-1:0] OUTPUT_LINE_O,
    output reg [31:0] PROGRAM_COUNTER_O,
    output reg DONE_O
);

    //------------------------------------------------------------
    // reset release
    //------------------------------------------------------------
    reg rst_meta_q;
    reg rst_sync_q;

    // two stages so every register leaves reset on the same edge
    always @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    wire rst_n = rst_sync_q;

    //------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------
    localparam NSYNC = LINES + 4;
    wire [NSYNC-1:0] pin_raw;
    reg [NSYNC-1:0] pin_clean_q;
    assign pin_raw = {POSITION_ERROR_I, DEVIATION_ERROR_I, EXTERNAL_ALARM_I,
                      TIMEOUT_ERROR_I, INPUT_LINE_I};

    // three flops per pin; the level moves once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            reg s1_q;
            reg s2_q;
            reg s3_q;
            always @(posedge CLOCK_I or negedge rst_n) begin
                if (!rst_n) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    pin_clean_q[gi] <= 1'b0;
                end else begin
                    s1_q <= pin_raw[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        pin_clean_q[gi] <= s3_q;
                    end
                end
            end
        end
    endgenerate

    wire [LINES-1:0] in_level = pin_clean_q[LINES-1:0];
    wire [3:0] err_flags = pin_clean_q[NSYNC-1:LINES];

    //------------------------------------------------------------
    // register bus
    //------------------------------------------------------------
    reg [31:0] cmd_q;
    reg [31:0] value_q;
    reg [7:0] status_q;
    reg [31:0] result_q;
    reg [31:0] accu_q;
    reg [31:0] accu_d;
    reg [31:0] result_d;
    reg [7:0] status_d;
    reg [31:0] pc_d;
    reg [2:0] flags_q;                  // zero, greater, lower of last compare
    reg [2:0] flags_d;
    reg [7:0] aw_addr_q;
    reg aw_have_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg w_have_q;
    reg exec_q;
    wire do_write = aw_have_q && w_have_q && !S_AXI_BVALID_O;
    wire [31:0] wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    wire [31:0] wmerge_cmd = (cmd_q & ~wmask) | (w_data_q & wmask);

    // address and data are caught independently, in either order
    always @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            S_AXI_AWREADY_O <= 1'b0;
            S_AXI_WREADY_O <= 1'b0;
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= 2'h0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= `IORABU_RST_WORD;
            w_strb_q <= 4'h0;
            cmd_q <= `IORABU_RST_WORD;
            value_q <= `IORABU_RST_WORD;
            exec_q <= 1'b0;
        end else begin
            S_AXI_AWREADY_O <= !aw_have_q && !S_AXI_AWREADY_O && S_AXI_AWVALID_I;
            S_AXI_WREADY_O <= !w_have_q && !S_AXI_WREADY_O && S_AXI_WVALID_I;
            exec_q <= 1'b0;
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= S_AXI_AWADDR_I;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_have_q <= 1'b1;
                w_data_q <= S_AXI_WDATA_I;
                w_strb_q <= S_AXI_WSTRB_I;
            end
            if (do_write) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O <= 2'h0;
                if (aw_addr_q == `IORABU_REG_CMD) begin
                    // writing the command word launches execution
                    cmd_q <= wmerge_cmd;
                    exec_q <= 1'b1;
                end else if (aw_addr_q == `IORABU_REG_VALUE) begin
                    value_q <= (value_q & ~wmask) | (w_data_q & wmask);
                end else if (aw_addr_q != `IORABU_REG_OUTPUTS) begin
                    S_AXI_BRESP_O <= 2'h2;      // unmapped or read-only
                end
            end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
                S_AXI_BVALID_O <= 1'b0;
            end
        end
    end

    // output lines are held here so bank 2 reads back exactly what is driven
    always @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            OUTPUT_LINE_O <= {LINES{1'b0}};
        end else if (do_write && aw_addr_q == `IORABU_REG_OUTPUTS) begin
            OUTPUT_LINE_O <= w_data_q[LINES-1:0];
        end
    end

    // read channel, answered one cycle after the address is taken
    always @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= `IORABU_RST_WORD;
            S_AXI_RRESP_O <= 2'h0;
        end else begin
            S_AXI_ARREADY_O <= !S_AXI_ARREADY_O && !S_AXI_RVALID_O && S_AXI_ARVALID_I;
            if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
                S_AXI_RVALID_O <= 1'b1;
                S_AXI_RRESP_O <= 2'h0;
                if (S_AXI_ARADDR_I == `IORABU_REG_CMD) begin
                    S_AXI_RDATA_O <= cmd_q;
                end else if (S_AXI_ARADDR_I == `IORABU_REG_VALUE) begin
                    S_AXI_RDATA_O <= value_q;
                end else if (S_AXI_ARADDR_I == `IORABU_REG_STATUS) begin
                    S_AXI_RDATA_O <= {21'h000000, flags_q, status_q};
                end else if (S_AXI_ARADDR_I == `IORABU_REG_RESULT) begin
                    S_AXI_RDATA_O <= result_q;
                end else if (S_AXI_ARADDR_I == `IORABU_REG_ACCU) begin
                    S_AXI_RDATA_O <= accu_q;
                end else if (S_AXI_ARADDR_I == `IORABU_REG_PC) begin
                    S_AXI_RDATA_O <= PROGRAM_COUNTER_O;
                end else if (S_AXI_ARADDR_I == `IORABU_REG_OUTPUTS) begin
                    S_AXI_RDATA_O <= {{(32-LINES){1'b0}}, OUTPUT_LINE_O};
                end else if (S_AXI_ARADDR_I == `IORABU_REG_ERRORS) begin
                    S_AXI_RDATA_O <= {28'h0000000, err_flags};
                end else begin
                    S_AXI_RDATA_O <= `IORABU_RST_WORD;
                    S_AXI_RRESP_O <= 2'h2;
                end
            end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
                S_AXI_RVALID_O <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------
    // command execution
    //------------------------------------------------------------
    wire [7:0] ins = cmd_q[`IORABU_CMD_INS_LSB +: 8];
    wire [7:0] typ = cmd_q[`IORABU_CMD_TYPE_LSB +: 8];
    wire [7:0] bank = cmd_q[`IORABU_CMD_BANK_LSB +: 8];
    wire standalone = cmd_q[`IORABU_CMD_STANDALONE_BIT];
    wire [1:0] port = typ[1:0];
    wire port_ok = (typ < LINES);
    wire signed [31:0] acc_s = accu_q;
    wire signed [31:0] opd_s = value_q;
    wire [63:0] product = acc_s * opd_s;
    reg [31:0] rd_val;
    reg rd_ok;
    reg cond_hit;
    reg cond_ok;

    // input read selection; all banks are live together, no mode switch
    always @* begin
        rd_val = `IORABU_RST_WORD;
        rd_ok = port_ok;
        if (bank == `IORABU_BANK_DIGITAL) begin
            rd_val = {31'h00000000, in_level[port]};
        end else if (bank == `IORABU_BANK_ANALOG) begin
            rd_val = {{(32-ADC_W){1'b0}}, ADC_VALUE_I[port*ADC_W +: ADC_W]};
        end else if (bank == `IORABU_BANK_OUTPUTS) begin
            rd_val = {31'h00000000, OUTPUT_LINE_O[port]};
        end else begin
            rd_ok = 1'b0;
        end
    end

    // jump condition decode
    always @* begin
        cond_ok = 1'b1;
        case (typ)
            `IORABU_COND_NULL: cond_hit = flags_q[2];
            `IORABU_COND_NONNULL: cond_hit = !flags_q[2];
            `IORABU_COND_SAME: cond_hit = flags_q[2];
            `IORABU_COND_DIFFER: cond_hit = !flags_q[2];
            `IORABU_COND_ABOVE_STRICT: cond_hit = flags_q[1];
            `IORABU_COND_ABOVE_OR_SAME: cond_hit = flags_q[1] | flags_q[2];
            `IORABU_COND_BELOW_STRICT: cond_hit = flags_q[0];
            `IORABU_COND_BELOW_OR_SAME: cond_hit = flags_q[0] | flags_q[2];
            `IORABU_COND_TIMEOUT: cond_hit = err_flags[0];
            `IORABU_COND_ALARM: cond_hit = err_flags[1];
            `IORABU_COND_DEVIATION: cond_hit = err_flags[2];
            `IORABU_COND_POSITION: cond_hit = err_flags[3];
            default: begin
                cond_hit = 1'b0;
                cond_ok = 1'b0;
            end
        endcase
    end

    // next state of accumulator, flags, counter and reply
    always @* begin
        accu_d = accu_q;
        flags_d = flags_q;
        pc_d = PROGRAM_COUNTER_O + 32'h00000001;
        status_d = `IORABU_STATUS_OK;
        result_d = `IORABU_RST_WORD;
        if (ins == `IORABU_INS_INPUT_READ) begin
            if (rd_ok) begin
                result_d = rd_val;
                if (standalone) begin
                    accu_d = rd_val;
                end
            end else begin
                status_d = `IORABU_STATUS_BAD_TYPE;
            end
        end else if (ins == `IORABU_INS_ARITH) begin
            result_d = value_q;
            case (typ)
                `IORABU_OP_ADD: accu_d = accu_q + value_q;
                `IORABU_OP_SUB: accu_d = accu_q - value_q;
                `IORABU_OP_PRODUCT: accu_d = product[31:0];
                `IORABU_OP_DIV: if (value_q != 32'h00000000) accu_d = acc_s / opd_s;
                `IORABU_OP_REMAINDER: if (value_q != 32'h00000000) accu_d = acc_s % opd_s;
                `IORABU_OP_AND: accu_d = accu_q & value_q;
                `IORABU_OP_OR: accu_d = accu_q | value_q;
                `IORABU_OP_XOR: accu_d = accu_q ^ value_q;
                `IORABU_OP_INVERT: accu_d = ~accu_q;
                `IORABU_OP_LOAD: accu_d = value_q;
                default: status_d = `IORABU_STATUS_BAD_TYPE;
            endcase
        end else if (ins == `IORABU_INS_COMPARE) begin
            // type and bank are don't care here
            flags_d = {acc_s == opd_s, acc_s > opd_s, acc_s < opd_s};
        end else if (ins == `IORABU_INS_COND_JUMP) begin
            if (!cond_ok) begin
                status_d = `IORABU_STATUS_BAD_TYPE;
            end else if (cond_hit) begin
                pc_d = value_q;
            end
        end else begin
            status_d = `IORABU_STATUS_BAD_CMD;
            pc_d = PROGRAM_COUNTER_O;
        end
    end

    // one command executes in the cycle after its command word is written
    always @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            accu_q <= `IORABU_RST_WORD;
            flags_q <= 3'h0;
            status_q <= 8'h00;
            result_q <= `IORABU_RST_WORD;
            PROGRAM_COUNTER_O <= `IORABU_RST_WORD;
            DONE_O <= 1'b0;
        end else begin
            DONE_O <= exec_q;
            if (exec_q) begin
                accu_q <= accu_d;
                flags_q <= flags_d;
                status_q <= status_d;
                result_q <= result_d;
                PROGRAM_COUNTER_O <= pc_d;
            end
        end
    end

endmodule // iorabu_top
`default_nettype wire

// file: tb/iorabu_monitor.sv
// checker on the top-level ports of the command execution unit
`timescale 1ns/1ps
`default_nettype none
`include "iorabu_consts.vh"
module iorabu_monitor (
    input wire logic CLOCK_I,
    input wire logic RST_B_I,
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    input wire logic S_AXI_AWREADY_O,
    input wire logic S_AXI_WREADY_O,
    input wire logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic DONE_O,
    input wire logic [31:0] PROGRAM_COUNTER_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_B_I);
    // ----------------------------------------
    // helper: last accepted write address was the command register
    // ----------------------------------------
    logic cmd_q;
    always @(posedge CLOCK_I or negedge RST_B_I) begin
        if (!RST_B_I) cmd_q <= 1'b0;
        else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) cmd_q <= (S_AXI_AWADDR_I == `IORABU_REG_CMD);
    end
    // ----------------------------------------
    // sequences and properties
    // ----------------------------------------
    sequence s_ar_taken; S_AXI_ARVALID_I && S_AXI_ARREADY_O; endsequence
    sequence s_cmd_done; $rose(S_AXI_BVALID_O) && cmd_q; endsequence
    property p_awready_pulse; S_AXI_AWREADY_O |=> !S_AXI_AWREADY_O; endproperty
    property p_wready_pulse; S_AXI_WREADY_O |=> !S_AXI_WREADY_O; endproperty
    property p_read_answer; s_ar_taken |=> S_AXI_RVALID_O; endproperty
    property p_rvalid_drop; S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O; endproperty
    property p_bvalid_drop; S_AXI_BVALID_O && S_AXI_BREADY_I |=> !S_AXI_BVALID_O; endproperty
    property p_done_after_cmd; s_cmd_done |-> ##[0:2] DONE_O; endproperty
    property p_done_pulse; DONE_O |=> !DONE_O; endproperty
    property p_done_cause; DONE_O |-> cmd_q; endproperty
    property p_pc_at_done; $changed(PROGRAM_COUNTER_O) |-> DONE_O; endproperty
    a_awready_pulse: assert property (p_awready_pulse)
        else $error("write address ready longer than one cycle");
    a_wready_pulse: assert property (p_wready_pulse)
        else $error("write data ready longer than one cycle");
    a_read_answer: assert property (p_read_answer)
        else $error("read data not valid one cycle after address taken");
    a_rvalid_drop: assert property (p_rvalid_drop)
        else $error("read data still valid after handshake");
    a_bvalid_drop: assert property (p_bvalid_drop)
        else $error("write response still valid after handshake");
    a_done_after_cmd: assert property (p_done_after_cmd)
        else $error("command write not followed by done");
    a_done_pulse: assert property (p_done_pulse)
        else $error("done longer than one cycle");
    a_done_cause: assert property (p_done_cause)
        else $error("done without a command write");
    a_pc_at_done: assert property (p_pc_at_done)
        else $error("program counter moved outside command completion");
endmodule // iorabu_monitor
`default_nettype wire

// file: tb/iorabu_io_model.sv
// model of the input lines, converters and error sources feeding the unit
`timescale 1ns/1ps
`default_nettype none
module iorabu_io_model (
    input wire logic clk_i,
    input wire logic [3:0] lvl_i,
    input wire logic [63:0] adc_i,
    input wire logic [3:0] err_i,
    output logic [3:0] line_o = 4'h0,
    output logic [63:0] adc_o = 64'h0,
    output logic [3:0] err_o = 4'h0
);
    // levels and conversions move only after an edge, as a real front end would
    always @(posedge clk_i) begin
        line_o <= lvl_i;
        adc_o <= adc_i;
        err_o <= err_i;
    end
endmodule // iorabu_io_model
`default_nettype wire

// file: tb/iorabu_top_bench.sv
// self-checking bench for the command execution unit
`timescale 1ns/1ps
`default_nettype none
`include "iorabu_consts.vh"
module iorabu_top_bench;
    logic clk, rst_b, aw_valid, aw_ready, w_valid, w_ready, b_valid, b_ready;
    logic ar_valid, ar_ready, r_valid, r_ready, done;
    logic [7:0] aw_addr, ar_addr;
    logic [31:0] w_data, r_data, pc_out, acc, pc, v, e, tgt, cv;
    logic [1:0] b_resp, r_resp;
    logic [3:0] lvl, err, in_line, err_src, out_line, outs;
    logic [63:0] adc, adc_val;
    logic [7:0] op;
    logic [33:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic tk, eq, gt, lt;
    integer seed, miscompares, num_checks, cycles, i, b, p, c;
    // ----------------------------------------
    // design, front-end model, clock
    // ----------------------------------------
    iorabu_top dut (.CLOCK_I(clk), .RST_B_I(rst_b), .S_AXI_AWADDR_I(aw_addr),
        .S_AXI_AWVALID_I(aw_valid), .S_AXI_AWREADY_O(aw_ready), .S_AXI_WDATA_I(w_data),
        .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(w_valid), .S_AXI_WREADY_O(w_ready),
        .S_AXI_BRESP_O(b_resp), .S_AXI_BVALID_O(b_valid), .S_AXI_BREADY_I(b_ready),
        .S_AXI_ARADDR_I(ar_addr), .S_AXI_ARVALID_I(ar_valid), .S_AXI_ARREADY_O(ar_ready),
        .S_AXI_RDATA_O(r_data), .S_AXI_RRESP_O(r_resp), .S_AXI_RVALID_O(r_valid),
        .S_AXI_RREADY_I(r_ready), .INPUT_LINE_I(in_line), .ADC_VALUE_I(adc_val),
        .TIMEOUT_ERROR_I(err_src[0]), .EXTERNAL_ALARM_I(err_src[1]),
        .DEVIATION_ERROR_I(err_src[2]), .POSITION_ERROR_I(err_src[3]),
        .OUTPUT_LINE_O(out_line), .PROGRAM_COUNTER_O(pc_out), .DONE_O(done));
    iorabu_io_model u_io (.clk_i(clk), .lvl_i(lvl), .adc_i(adc), .err_i(err),
        .line_o(in_line), .adc_o(adc_val), .err_o(err_src));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic chk(input logic [33:0] seen, input logic [33:0] want);
        num_checks++;
        if (seen !== want) begin
            miscompares++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // watcher: each read answer against the oldest note
    always @(posedge clk) begin
        if (r_valid && r_ready && exp_q.size() > 0) begin
            chk({r_resp, r_data & msk_q[0]}, exp_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end
    // hang guard, far above the cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares++;
            results();
        end
    end
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs = 2'b00);
        aw_addr <= a;
        w_data <= d;
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        do begin
            @(posedge clk);
            if (aw_valid && aw_ready) aw_valid <= 1'b0;
            if (w_valid && w_ready) w_valid <= 1'b0;
        end while (!(b_valid && b_ready));
        chk(b_resp, rs);
        b_ready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x,
            input logic [31:0] m = 32'hFFFFFFFF, input logic [1:0] rs = 2'b00);
        exp_q.push_back({rs, x & m});
        msk_q.push_back(m);
        ar_addr <= a;
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        do begin
            @(posedge clk);
            if (ar_valid && ar_ready) ar_valid <= 1'b0;
        end while (!(r_valid && r_ready));
        r_ready <= 1'b0;
        @(posedge clk);
    endtask
    // value first, then command; done follows the response
    task automatic cmd(input logic [7:0] ins, input logic [7:0] t, input logic [7:0] bk,
            input logic sa, input logic [31:0] val);
        wr(`IORABU_REG_VALUE, val);
        wr(`IORABU_REG_CMD, {7'h00, sa, bk, t, ins});
        repeat (2) @(posedge clk);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        seed = 32'hC20B;
        {miscompares, num_checks, cycles} = 0;
        {aw_valid, w_valid, b_ready, ar_valid, r_ready} <= 5'h00;
        {aw_addr, ar_addr, w_data} <= 48'h0;
        rst_b <= 1'b0;
        {lvl, err, adc} <= 72'h0;
        {acc, pc} = 64'h0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        rd(`IORABU_REG_ACCU, 32'h0);
        rd(`IORABU_REG_PC, 32'h0);
        rd(8'h20, 32'h0, 32'hFFFFFFFF, 2'b10);
        wr(`IORABU_REG_ACCU, $random(seed), 2'b10);
        rd(`IORABU_REG_ACCU, 32'h0);
        // arithmetic: every operation, both modes, zero divisors first
        for (i = 0; i < 40; i++) begin
            op = (i < 10) ? i : $unsigned($random(seed)) % 10;
            v = (i == 3 || i == 4) ? 32'h0 : $random(seed);
            if ((op == 3 || op == 4) && v == 32'hFFFFFFFF) v = 32'h7;
            case (op)
                0: acc = acc + v;
                1: acc = acc - v;
                2: acc = acc * v;
                3: if (v != 0) acc = $signed(acc) / $signed(v);
                4: if (v != 0) acc = $signed(acc) % $signed(v);
                5: acc = acc & v;
                6: acc = acc | v;
                7: acc = acc ^ v;
                8: acc = ~acc;
                default: acc = v;
            endcase
            cmd(`IORABU_INS_ARITH, op, 8'h00, i[0], v);
            pc++;
            rd(`IORABU_REG_ACCU, acc);
            rd(`IORABU_REG_RESULT, v);
            rd(`IORABU_REG_STATUS, 32'h64, 32'hFF);
        end
        // input reads over all banks and ports, odd ports standalone
        lvl <= $random(seed);
        adc <= {16'hFFFF, $random(seed), 16'h012E};
        outs = $random(seed);
        wr(`IORABU_REG_OUTPUTS, {28'h0, outs});
        chk(out_line, outs);
        repeat (8) @(posedge clk);
        for (b = 0; b < 3; b++) begin
            for (p = 0; p < 4; p++) begin
                e = (b == 0) ? lvl[p] : (b == 1) ? adc[16*p +: 16] : outs[p];
                cmd(`IORABU_INS_INPUT_READ, p, b, p[0], $random(seed));
                pc++;
                if (p[0]) acc = e;
                rd(`IORABU_REG_RESULT, e);
                rd(`IORABU_REG_ACCU, acc);
            end
        end
        // compare with junk type and bank, then every comparison jump
        cmd(`IORABU_INS_ARITH, `IORABU_OP_LOAD, 8'h00, 1'b1, 32'hFFFFFF9C);
        acc = 32'hFFFFFF9C;
        pc++;
        for (i = 0; i < 24; i++) begin
            cv = acc + (i / 8) - 1;
            c = i % 8;
            tgt = $unsigned($random(seed)) % 256;
            eq = (acc == cv);
            gt = ($signed(acc) > $signed(cv));
            lt = ($signed(acc) < $signed(cv));
            case (c)
                0, 2: tk = eq;
                1, 3: tk = !eq;
                4: tk = gt;
                5: tk = gt || eq;
                6: tk = lt;
                default: tk = lt || eq;
            endcase
            cmd(`IORABU_INS_COMPARE, $random(seed), $random(seed), 1'b1, cv);
            pc++;
            cmd(`IORABU_INS_COND_JUMP, c, 8'h00, 1'b1, tgt);
            pc = tk ? tgt : pc + 1;
            rd(`IORABU_REG_PC, pc);
        end
        // error jumps: other flags set, then the flag alone
        for (i = 0; i < 8; i++) begin
            c = 8 + i / 2;
            err <= i[0] ? 4'h1 << (c - 8) : ~(4'h1 << (c - 8));
            tgt = $unsigned($random(seed)) % 256;
            repeat (8) @(posedge clk);
            cmd(`IORABU_INS_COND_JUMP, c, 8'h00, 1'b1, tgt);
            pc = i[0] ? tgt : pc + 1;
            rd(`IORABU_REG_PC, pc);
        end
        // unknown instruction is refused and the counter holds
        cmd(8'h30, 8'h00, 8'h00, 1'b0, 32'h0);
        rd(`IORABU_REG_STATUS, 32'h02, 32'hFF);
        rd(`IORABU_REG_PC, pc);
        chk(pc_out, pc);
        results();
    end
endmodule // iorabu_top_bench
bind iorabu_top iorabu_monitor u_mon (.CLOCK_I, .RST_B_I, .S_AXI_AWADDR_I, .S_AXI_AWVALID_I,
    .S_AXI_AWREADY_O, .S_AXI_WREADY_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_ARVALID_I,
    .S_AXI_ARREADY_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I, .DONE_O, .PROGRAM_COUNTER_O);
`default_nettype wire
